// ===== hw/ufid_pkg.sv
package ufid_pkg;

  // ==========================================================================
  // Queue geometry
  localparam int unsigned TX_WIDTH     = 8;
  localparam int unsigned RX_WIDTH     = 12;
  localparam int unsigned QUEUE_DEPTH  = 32;
  localparam int unsigned ERR_WIDTH    = 4;

  // ==========================================================================
  // Register map, byte addresses on the 12-bit APB address
  localparam int unsigned   ADDR_WIDTH  = 12;
  localparam logic [11:0]   OFS_DATA    = 12'h000;
  localparam logic [11:0]   OFS_FLAG    = 12'h018;
  localparam logic [11:0]   OFS_ILPR    = 12'h020;
  localparam logic [11:0]   OFS_CTRL    = 12'h030;

  // ==========================================================================
  // Field positions
  localparam int unsigned FLAG_CTS_BIT  = 0;
  localparam int unsigned FLAG_RXFE_BIT = 4;
  localparam int unsigned FLAG_TXFF_BIT = 5;
  localparam int unsigned FLAG_RXFF_BIT = 6;
  localparam int unsigned FLAG_TXFE_BIT = 7;
  localparam int unsigned CTRL_FEN_BIT  = 0;
  localparam int unsigned CTRL_LPS_BIT  = 1;
  localparam int unsigned DIV_WIDTH     = 8;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] DIV_RESET      = 8'h00;
  localparam logic       FEN_RESET      = 1'b0;
  localparam logic       LPS_RESET      = 1'b0;

  typedef struct packed {
    logic [3:0] err;
    logic [7:0] data;
  } ufid_rx_entry_t;

endpackage

// ===== hw/ufid_fifo.sv
`timescale 1ns/1ps
module ufid_fifo
  import ufid_pkg::*;
#(
  parameter int unsigned WIDTH = TX_WIDTH,
  parameter int unsigned DEPTH = QUEUE_DEPTH
) (
  input  wire logic                       i_clk,
  input  wire logic                       i_rst,
  input  wire logic                       i_fen,
  input  wire logic                       i_in_valid,
  output logic                            o_in_ready,
  input  wire logic [WIDTH-1:0]           i_in_data,
  output logic                            o_out_valid,
  input  wire logic                       i_out_ready,
  output logic [WIDTH-1:0]                o_out_data,
  output logic [$clog2(DEPTH+1)-1:0]      o_count
);
  localparam int unsigned PW = $clog2(DEPTH);
  localparam int unsigned CW = $clog2(DEPTH+1);
  localparam logic [CW-1:0] CAP_FULL = CW'(DEPTH);
  localparam logic [CW-1:0] CAP_ONE  = CW'(1);

  if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_chk
    $error("ufid_fifo: DEPTH must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0]    wr_q;
  logic [PW-1:0]    rd_q;
  logic [CW-1:0]    count_q;
  logic [CW-1:0]    cap;
  logic             push;
  logic             pop;

  // ==========================================================================
  // With queueing off the same storage is capped at one entry, so it acts as
  // a holding register without a second data path.
  assign cap         = i_fen ? CAP_FULL : CAP_ONE;
  assign o_in_ready  = count_q < cap;
  assign o_out_valid = count_q != '0;
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;
  assign o_out_data  = mem_q[rd_q];
  assign o_count     = count_q;

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_q[wr_q] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_q    <= '0;
      rd_q    <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + PW'(1);
      end
      if (pop) begin
        rd_q <= rd_q + PW'(1);
      end
      count_q <= count_q + CW'(push) - CW'(pop);
    end
  end
endmodule // ufid_fifo

// ===== hw/ufid_skid.sv
`timescale 1ns/1ps
module ufid_skid
  import ufid_pkg::*;
#(
  parameter int unsigned WIDTH = TX_WIDTH
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic [WIDTH-1:0]      o_out_data
);
  if (WIDTH < 1) begin : g_chk
    $error("ufid_skid: WIDTH must be at least 1");
  end

  logic [WIDTH-1:0] head_q;
  logic [WIDTH-1:0] tail_q;
  logic [1:0]       cnt_q;
  logic             push;
  logic             pop;

  // ==========================================================================
  // The second slot catches the word in flight when the receiver stalls.
  assign o_in_ready  = cnt_q != 2'h2;
  assign o_out_valid = cnt_q != 2'h0;
  assign o_out_data  = head_q;
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      head_q <= '0;
      tail_q <= '0;
      cnt_q  <= 2'h0;
    end else begin
      case ({push, pop})
        2'b10: begin
          if (cnt_q == 2'h0) begin
            head_q <= i_in_data;
          end else begin
            tail_q <= i_in_data;
          end
          cnt_q <= cnt_q + 2'h1;
        end
        2'b01: begin
          head_q <= tail_q;
          cnt_q  <= cnt_q - 2'h1;
        end
        2'b11: begin
          if (cnt_q == 2'h1) begin
            head_q <= i_in_data;
          end else begin
            head_q <= tail_q;
            tail_q <= i_in_data;
          end
        end
        default: begin
        end
      endcase
    end
  end
endmodule // ufid_skid

// ===== hw/ufid_top.sv
// Notes on behaviour
// - Flag bit 0 reads 1 while the clear-to-send input is low and cannot be written.
// - The transmit queue keeps up to 32 bytes of 8 bits in arrival order.
// - Bytes written to the data register while the transmit queue has room stay queued until the transmit logic takes them.
// - With queueing off the transmit path holds three bytes: one in the queue and two in the staging slots.
// - The receive queue keeps up to 32 entries of 12 bits in arrival order.
// - Each received character and its error bits form one entry kept until software reads it.
// - With queueing off the receive path holds a single entry.
// - The low-power divisor register holds 8 writable bits and reads zero above them.
// - The low-power pulse reference runs at the reference clock rate divided by the divisor.
// - Reset clears the low-power divisor to zero.
`timescale 1ns/1ps
module ufid_top
  import ufid_pkg::*;
#(
  parameter int unsigned DEPTH = QUEUE_DEPTH
) (
  input  wire logic                  i_clk,
  input  wire logic                  i_rst,
  input  wire logic                  i_psel,
  input  wire logic                  i_penable,
  input  wire logic                  i_pwrite,
  input  wire logic [ADDR_WIDTH-1:0] i_paddr,
  input  wire logic [31:0]           i_pwdata,
  output logic [31:0]                o_prdata,
  output logic                       o_pready,
  output logic                       o_pslverr,
  input  wire logic                  i_cts_n,
  output logic                       o_tx_valid,
  input  wire logic                  i_tx_ready,
  output logic [TX_WIDTH-1:0]        o_tx_byte,
  input  wire logic                  i_rx_valid,
  output logic                       o_rx_ready,
  input  wire ufid_rx_entry_t        i_rx_entry,
  output logic                       o_ir_low_power_pulse_clock
);
  localparam int unsigned CW = $clog2(DEPTH+1);
  localparam logic [CW-1:0] CNT_ONE   = CW'(1);
  localparam logic [CW-1:0] CNT_DEPTH = CW'(DEPTH);

  if (DEPTH < 2) begin : g_chk
    $error("ufid_top: DEPTH must be at least 2");
  end

  // ==========================================================================
  // APB decode
  logic           setup;
  logic           access;
  logic           wr_data;
  logic           wr_ilpr;
  logic           wr_ctrl;
  logic           rd_data;
  logic           mapped;
  logic [31:0]    rdata;
  logic [31:0]    prdata_q;
  logic           rx_seen_q;
  logic           fen_q;
  logic           lps_q;
  logic [7:0]     div_q;

  assign setup    = i_psel && !i_penable;
  assign access   = i_psel && i_penable;
  assign mapped   = (i_paddr == OFS_DATA) || (i_paddr == OFS_FLAG) ||
                    (i_paddr == OFS_ILPR) || (i_paddr == OFS_CTRL);
  assign wr_data  = access && i_pwrite && (i_paddr == OFS_DATA);
  assign wr_ilpr  = access && i_pwrite && (i_paddr == OFS_ILPR);
  assign wr_ctrl  = access && i_pwrite && (i_paddr == OFS_CTRL);
  // A pop only happens if the entry shown in the read data was really there.
  assign rd_data  = access && !i_pwrite && (i_paddr == OFS_DATA) && rx_seen_q;
  assign o_pready  = 1'b1;
  assign o_pslverr = access && !mapped;
  assign o_prdata  = prdata_q;

  // ==========================================================================
  // Queues
  logic           tx_in_ready;
  logic           tx_q_valid;
  logic [7:0]     tx_q_byte;
  logic           sk_in_ready;
  logic [CW-1:0]  tx_count;
  logic [CW-1:0]  rx_count;
  logic           rx_valid;
  ufid_rx_entry_t rx_head;

  ufid_fifo #(.WIDTH(TX_WIDTH), .DEPTH(DEPTH)) u_txq (
    .i_clk       (i_clk),
    .i_rst       (i_rst),
    .i_fen       (fen_q),
    .i_in_valid  (wr_data),
    .o_in_ready  (tx_in_ready),
    .i_in_data   (i_pwdata[TX_WIDTH-1:0]),
    .o_out_valid (tx_q_valid),
    .i_out_ready (sk_in_ready),
    .o_out_data  (tx_q_byte),
    .o_count     (tx_count)
  );

  // Staging the head byte lets the transmit logic stall without losing it.
  ufid_skid #(.WIDTH(TX_WIDTH)) u_txsk (
    .i_clk       (i_clk),
    .i_rst       (i_rst),
    .i_in_valid  (tx_q_valid),
    .o_in_ready  (sk_in_ready),
    .i_in_data   (tx_q_byte),
    .o_out_valid (o_tx_valid),
    .i_out_ready (i_tx_ready),
    .o_out_data  (o_tx_byte)
  );

  ufid_fifo #(.WIDTH(RX_WIDTH), .DEPTH(DEPTH)) u_rxq (
    .i_clk       (i_clk),
    .i_rst       (i_rst),
    .i_fen       (fen_q),
    .i_in_valid  (i_rx_valid),
    .o_in_ready  (o_rx_ready),
    .i_in_data   (i_rx_entry),
    .o_out_valid (rx_valid),
    .i_out_ready (rd_data),
    .o_out_data  (rx_head),
    .o_count     (rx_count)
  );

  // ==========================================================================
  // Registers
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      div_q <= DIV_RESET;
    end else if (wr_ilpr) begin
      div_q <= i_pwdata[DIV_WIDTH-1:0];
    end
  end

  // Neither a zero divisor nor setting the select bit first is trapped here;
  // a zero divisor simply keeps the pulse reference quiet.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      fen_q <= FEN_RESET;
      lps_q <= LPS_RESET;
    end else if (wr_ctrl) begin
      fen_q <= i_pwdata[CTRL_FEN_BIT];
      lps_q <= i_pwdata[CTRL_LPS_BIT];
    end
  end

  always_comb begin
    rdata = 32'h0000_0000;
    case (i_paddr)
      OFS_DATA: begin
        if (rx_valid) begin
          rdata[RX_WIDTH-1:0] = {rx_head.err, rx_head.data};
        end
      end
      OFS_FLAG: begin
        rdata[FLAG_CTS_BIT]  = !i_cts_n;
        rdata[FLAG_RXFE_BIT] = !rx_valid;
        rdata[FLAG_TXFF_BIT] = !tx_in_ready;
        rdata[FLAG_RXFF_BIT] = !o_rx_ready;
        rdata[FLAG_TXFE_BIT] = !tx_q_valid;
      end
      OFS_ILPR: begin
        rdata[DIV_WIDTH-1:0] = div_q;
      end
      OFS_CTRL: begin
        rdata[CTRL_FEN_BIT] = fen_q;
        rdata[CTRL_LPS_BIT] = lps_q;
      end
      default: begin
        rdata = 32'h0000_0000;
      end
    endcase
  end

  // Read data is caught in the setup phase so it comes from a flip-flop.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      prdata_q  <= 32'h0000_0000;
      rx_seen_q <= 1'b0;
    end else if (setup && !i_pwrite) begin
      prdata_q  <= rdata;
      rx_seen_q <= rx_valid;
    end
  end

  // ==========================================================================
  // Low-power pulse reference
  logic       lp_run;
  logic [7:0] lp_cnt_q;
  logic       lp_pulse_q;

  assign lp_run = lps_q && (div_q != DIV_RESET);
  assign o_ir_low_power_pulse_clock = lp_pulse_q;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      lp_cnt_q   <= 8'h00;
      lp_pulse_q <= 1'b0;
    end else if (!lp_run) begin
      lp_cnt_q   <= 8'h00;
      lp_pulse_q <= 1'b0;
    end else if (lp_cnt_q == 8'h00) begin
      lp_cnt_q   <= div_q - 8'h01;
      lp_pulse_q <= 1'b1;
    end else begin
      lp_cnt_q   <= lp_cnt_q - 8'h01;
      lp_pulse_q <= 1'b0;
    end
  end

  // ==========================================================================
  // Checks
  logic [8:0] gap_q;
  logic [7:0] per_div_q;
  logic [7:0] prev_div_q;
  logic       seen_q;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      gap_q      <= 9'h000;
      per_div_q  <= 8'h00;
      prev_div_q <= 8'h00;
      seen_q     <= 1'b0;
    end else begin
      gap_q <= lp_pulse_q ? 9'h001 : ((gap_q == 9'h1ff) ? gap_q : gap_q + 9'h001);
      // A period is only measured once a pulse of the current run has gone by,
      // so the first pulse after the select bit is set is never judged.
      seen_q <= lp_run && (seen_q || lp_pulse_q);
      if (lp_run && lp_cnt_q == 8'h00) begin
        per_div_q  <= div_q;
        prev_div_q <= per_div_q;
      end
    end
  end

  property p_cts_flag;
    @(posedge i_clk) disable iff (i_rst)
    (setup && !i_pwrite && i_paddr == OFS_FLAG) |=> (o_prdata[FLAG_CTS_BIT] == !$past(i_cts_n));
  endproperty
  a_cts_flag: assert property (p_cts_flag) else $error("CTS flag does not mirror inverted input");

  property p_tx_cap;
    @(posedge i_clk) disable iff (i_rst) tx_count <= CNT_DEPTH;
  endproperty
  a_tx_cap: assert property (p_tx_cap) else $error("Transmit queue exceeds its depth");

  sequence s_tx_accept;
    wr_data && tx_in_ready && !(tx_q_valid && sk_in_ready);
  endsequence
  property p_tx_hold;
    @(posedge i_clk) disable iff (i_rst) s_tx_accept |=> tx_count == $past(tx_count) + CNT_ONE;
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("Written byte not held in transmit queue");

  property p_tx_single;
    @(posedge i_clk) disable iff (i_rst) !fen_q && !$past(fen_q) |-> tx_count <= CNT_ONE;
  endproperty
  a_tx_single: assert property (p_tx_single) else $error("Transmit holding register holds more than one");

  property p_rx_cap;
    @(posedge i_clk) disable iff (i_rst) rx_count <= CNT_DEPTH;
  endproperty
  a_rx_cap: assert property (p_rx_cap) else $error("Receive queue exceeds its depth");

  sequence s_rx_accept;
    i_rx_valid && o_rx_ready && !rd_data;
  endsequence
  property p_rx_keep;
    @(posedge i_clk) disable iff (i_rst) s_rx_accept |=> rx_count == $past(rx_count) + CNT_ONE;
  endproperty
  a_rx_keep: assert property (p_rx_keep) else $error("Received entry not stored");

  property p_rx_single;
    @(posedge i_clk) disable iff (i_rst) !fen_q && !$past(fen_q) |-> rx_count <= CNT_ONE;
  endproperty
  a_rx_single: assert property (p_rx_single) else $error("Receive holding register holds more than one");

  property p_div_upper;
    @(posedge i_clk) disable iff (i_rst)
    (setup && !i_pwrite && i_paddr == OFS_ILPR) |=> o_prdata == {24'h000000, $past(div_q)};
  endproperty
  a_div_upper: assert property (p_div_upper) else $error("Divisor read value wrong");

  property p_lp_period;
    @(posedge i_clk) disable iff (i_rst) (lp_pulse_q && seen_q) |-> gap_q == {1'b0, prev_div_q};
  endproperty
  a_lp_period: assert property (p_lp_period) else $error("Low-power pulse period differs from divisor");

  property p_div_reset;
    @(posedge i_clk) $fell(i_rst) |-> div_q == DIV_RESET;
  endproperty
  a_div_reset: assert property (p_div_reset) else $error("Divisor not cleared by reset");

endmodule // ufid_top

// ===== test/ufid_line_model.sv
`timescale 1ns/1ps
// ============================================================
// Serial line stand-in: drains the transmit stream and feeds receive entries.
module ufid_line_model
  import ufid_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_stall,
  input  wire logic       i_tx_valid,
  output logic            o_tx_ready,
  input  wire logic [7:0] i_tx_byte,
  output logic            o_rx_valid,
  input  wire logic       i_rx_ready,
  output ufid_rx_entry_t  o_rx_entry
);
  logic [7:0] tx_log [$];

  // A stalled line holds ready low so the design must keep every byte.
  assign o_tx_ready = !i_stall;

  initial begin
    o_rx_valid = 1'b0;
    o_rx_entry = '0;
  end

  always @(posedge i_clk) begin
    if (i_tx_valid && o_tx_ready) begin
      tx_log.push_back(i_tx_byte);
    end
  end

  // The entry lines show the inverse of the last entry once released.
  task automatic send_entry(input ufid_rx_entry_t e);
    int n;
    n = 0;
    @(posedge i_clk);
    o_rx_valid <= 1'b1;
    o_rx_entry <= e;
    do begin
      @(posedge i_clk);
      n++;
    end while (!i_rx_ready && n < 40);
    o_rx_valid <= 1'b0;
    o_rx_entry <= ~e;
  endtask
endmodule // ufid_line_model

// ===== test/test_ufid_top.sv
`timescale 1ns/1ps
module test_ufid_top;
  import ufid_pkg::*;
  logic                  i_clk = 1'b0;
  logic                  i_rst = 1'b1;
  logic                  psel = 1'b0;
  logic                  penable = 1'b0;
  logic                  pwrite = 1'b0;
  logic [ADDR_WIDTH-1:0] paddr = '0;
  logic [31:0]           pwdata = '0;
  logic [31:0]           prdata;
  logic                  pready;
  logic                  pslverr;
  logic                  cts_n = 1'b1;
  logic                  stall = 1'b0;
  logic                  tx_valid;
  logic                  tx_ready;
  logic [7:0]            tx_byte;
  logic                  rx_valid;
  logic                  rx_ready;
  ufid_rx_entry_t        rx_entry;
  logic                  pulse;
  logic                  slv;
  logic [31:0]           rd;
  int                    err_total = 0;
  int                    cmp_count = 0;
  int                    cyc = 0;

  always #50 i_clk = ~i_clk;

  ufid_top u_dut (
    .i_clk(i_clk), .i_rst(i_rst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_cts_n(cts_n), .o_tx_valid(tx_valid), .i_tx_ready(tx_ready), .o_tx_byte(tx_byte),
    .i_rx_valid(rx_valid), .o_rx_ready(rx_ready), .i_rx_entry(rx_entry),
    .o_ir_low_power_pulse_clock(pulse)
  );

  ufid_line_model u_line (
    .i_clk(i_clk), .i_stall(stall), .i_tx_valid(tx_valid), .o_tx_ready(tx_ready),
    .i_tx_byte(tx_byte), .o_rx_valid(rx_valid), .i_rx_ready(rx_ready), .o_rx_entry(rx_entry)
  );

  // ============================================================
  // Access tasks and comparison.
  task automatic give_verdict();
    $display("checks %0d errors %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Setup, then access; data and error are taken at the edge where ready is seen.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge i_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge i_clk);
    penable <= 1'b1;
    do @(posedge i_clk); while (pready !== 1'b1 && cyc < 20000);
    rd  = prdata;
    slv = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  task automatic flag_chk(input int b, input logic e);
    apb(1'b0, OFS_FLAG, 32'h0);
    chk({31'h0, rd[b]}, {31'h0, e});
  endtask

  task automatic drain(input int n);
    for (int k = 0; k < 300 && u_line.tx_log.size() < n; k++) @(posedge i_clk);
    repeat (4) @(posedge i_clk);
    chk(u_line.tx_log.size(), n);
  endtask

  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      give_verdict();
    end
  end

  // ============================================================
  // Main sequence.
  initial begin
    int n;
    int dv [3] = '{1, 3, 8};
    repeat (6) @(posedge i_clk);
    i_rst <= 1'b0;
    rd_chk(OFS_ILPR, 32'h0);
    @(posedge i_clk) cts_n <= 1'b0;
    flag_chk(FLAG_CTS_BIT, 1'b1);
    @(posedge i_clk) cts_n <= 1'b1;
    apb(1'b1, OFS_FLAG, 32'hffffffff);
    flag_chk(FLAG_CTS_BIT, 1'b0);
    apb(1'b1, OFS_ILPR, 32'hffffffa5);
    rd_chk(OFS_ILPR, 32'h000000a5);
    apb(1'b0, 12'h100, 32'h0);
    chk({31'h0, slv}, 32'h1);
    chk(rd, 32'h0);
    // Divisor is always loaded nonzero while the select bit is off.
    foreach (dv[j]) begin
      apb(1'b1, OFS_CTRL, 32'h0);
      apb(1'b1, OFS_ILPR, dv[j]);
      apb(1'b1, OFS_CTRL, 32'h2);
      repeat (10) @(posedge i_clk);
      n = 0;
      repeat (48) begin
        @(negedge i_clk);
        n += (pulse === 1'b1);
      end
      chk(n, 48 / dv[j]);
    end
    apb(1'b1, OFS_CTRL, 32'h1);
    @(posedge i_clk) stall <= 1'b1;
    for (int i = 0; i < 35; i++) apb(1'b1, OFS_DATA, i);
    flag_chk(FLAG_TXFF_BIT, 1'b1);
    flag_chk(FLAG_TXFE_BIT, 1'b0);
    @(posedge i_clk) stall <= 1'b0;
    drain(34);
    for (int i = 0; i < 34; i++) chk(u_line.tx_log[i], i);
    flag_chk(FLAG_TXFE_BIT, 1'b1);
    u_line.tx_log.delete();
    apb(1'b1, OFS_CTRL, 32'h0);
    @(posedge i_clk) stall <= 1'b1;
    for (int i = 0; i < 5; i++) apb(1'b1, OFS_DATA, 32'h50 + i);
    flag_chk(FLAG_TXFF_BIT, 1'b1);
    @(posedge i_clk) stall <= 1'b0;
    drain(3);
    for (int i = 0; i < 3; i++) chk(u_line.tx_log[i], 32'h50 + i);
    apb(1'b1, OFS_CTRL, 32'h1);
    for (int i = 0; i < 32; i++) u_line.send_entry(ufid_rx_entry_t'({i[3:0], ~i[7:0]}));
    flag_chk(FLAG_RXFF_BIT, 1'b1);
    for (int i = 0; i < 32; i++) rd_chk(OFS_DATA, {20'h0, i[3:0], ~i[7:0]});
    flag_chk(FLAG_RXFE_BIT, 1'b1);
    rd_chk(OFS_DATA, 32'h0);
    apb(1'b1, OFS_CTRL, 32'h0);
    u_line.send_entry(ufid_rx_entry_t'(12'h9c3));
    flag_chk(FLAG_RXFF_BIT, 1'b1);
    rd_chk(OFS_DATA, 32'h000009c3);
    flag_chk(FLAG_RXFE_BIT, 1'b1);
    apb(1'b1, OFS_ILPR, 32'h7e);
    @(posedge i_clk) i_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    rd_chk(OFS_ILPR, 32'h0);
    give_verdict();
  end
endmodule // test_ufid_top
